// [include/fcm_pkg.sv]
// Operation
// - Clock failure switches system to backup oscillator
// - Clock failure raises a non-maskable interrupt
// - Config field: bit1 monitors, bit0 allows software source/PLL selection
// - Fail flag shows failure; writing starts event
// - NMI fail flag write raises NMI only
// - Lock bit set rejects clock/PLL selection changes
// - Monitor actions never touch the lock bit
package fcm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int MON_TIMEOUT_NS = 1000;
  localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_NS * CLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source and PLL selection encodings
  localparam int SRC_W = 3;
  localparam int PLL_W = 3;
  localparam logic [SRC_W-1:0] SRC_FAST_INTERNAL = 3'h0;
  localparam logic [SRC_W-1:0] SRC_PRIMARY = 3'h2;
  localparam logic [SRC_W-1:0] SRC_BACKUP = 3'h7;
  localparam logic [SRC_W-1:0] RST_SOURCE = SRC_PRIMARY;
  localparam logic [PLL_W-1:0] RST_PLL = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CFG_SWITCH_BIT = 0;
  localparam int CFG_MONITOR_BIT = 1;
  localparam int OSC_FAIL_BIT = 3;
  localparam int OSC_LOCK_BIT = 7;
  localparam int NMI_FAIL_BIT = 1;
  localparam int CTRL_W = 8;
  localparam logic RST_LOCK = 1'b0;

  // Failure handling mode
  typedef enum logic [0:0] {
    MODE_NORMAL,
    MODE_FAILED
  } fcm_mode_e;

endpackage

// [core/fcm_activity_det.sv]
`timescale 1ns/10ps
module fcm_activity_det
  import fcm_pkg::*;
#(
  parameter int TIMEOUT_CYC = MON_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Monitor control and oscillator sample
  input wire logic i_enable,
  input wire logic i_osc_level,
  // Failure level
  output logic o_fail
);

  localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYC - 1);

  // A single-cycle window cannot tell a slow clock from a dead one
  if (TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("fcm_activity_det: TIMEOUT_CYC must be at least 2");
  end

  typedef struct packed {
    logic lvl;
    logic [CNT_W-1:0] cnt;
    logic fail;
  } fcm_det_s;

  fcm_det_s cur_reg;
  fcm_det_s cur_next;
  logic edge_seen;

  ////////////////////////////////////////////////////////////////////////////
  // Count cycles since the last level change of the oscillator
  always_comb begin
    cur_next = cur_reg;
    edge_seen = (i_osc_level != cur_reg.lvl);
    cur_next.lvl = i_osc_level;
    if (!i_enable || edge_seen) begin
      cur_next.cnt = '0;
    end else if (cur_reg.cnt != LAST) begin
      cur_next.cnt = cur_reg.cnt + CNT_W'(1);
    end
    // Sticky while enabled so one quiet window is one failure
    cur_next.fail = i_enable && (cur_reg.fail || (!edge_seen && cur_reg.cnt == LAST));
  end

  // State register
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign o_fail = cur_reg.fail;

  // Failure only after a full quiet window
  chk_det_timeout: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    $rose(o_fail) |-> ($past(cur_reg.cnt) == LAST) && $past(i_enable))
    else $error("detector failed before quiet window elapsed");

endmodule // fcm_activity_det

// [core/fcm_core.sv]
`timescale 1ns/10ps
module fcm_core
  import fcm_pkg::*;
#(
  parameter int TIMEOUT_CYC = MON_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Configuration word field: switching and monitor enables
  input wire logic [1:0] i_switch_monitor_config,
  // Sampled level of the monitored oscillator
  input wire logic i_osc_activity,
  // Software write of the oscillator control clock fail flag
  input wire logic i_clock_fail_flag_wr,
  input wire logic i_clock_fail_flag_wdata,
  // Software write of the NMI control clock fail flag
  input wire logic i_nmi_fail_flag_wr,
  input wire logic i_nmi_fail_flag_wdata,
  // Software write of the clock selection lock
  input wire logic i_clock_select_lock_wr,
  input wire logic i_clock_select_lock_wdata,
  // Software clock source and PLL selection requests
  input wire logic i_source_sel_wr,
  input wire logic [SRC_W-1:0] i_source_sel_wdata,
  input wire logic i_pll_sel_wr,
  input wire logic [PLL_W-1:0] i_pll_sel_wdata,
  // Clock selection outputs
  output logic [SRC_W-1:0] o_active_source,
  output logic [PLL_W-1:0] o_pll_select,
  output logic o_select_rejected,
  // Status and interrupt
  output logic o_clock_fail_flag,
  output logic o_nmi_fail_flag,
  output logic o_nmi_request,
  output logic o_clock_select_lock,
  output logic o_monitor_failed_mode,
  output logic [CTRL_W-1:0] o_osc_ctrl_view,
  output logic [CTRL_W-1:0] o_nmi_ctrl_view
);

  typedef struct packed {
    fcm_mode_e mode;
    logic [SRC_W-1:0] src;
    logic [PLL_W-1:0] pll;
    logic fail_flag;
    logic nmi_flag;
    logic nmi_req;
    logic lock;
    logic rejected;
    logic det_fail_d;
    logic [CTRL_W-1:0] osc_view;
    logic [CTRL_W-1:0] nmi_view;
  } fcm_core_s;

  fcm_core_s cur_reg;
  fcm_core_s cur_next;
  logic mon_en;
  logic sw_en;
  logic det_en;
  logic det_fail;
  logic fail_event;
  logic sw_event;
  logic nmi_set;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the configuration field
  assign mon_en = i_switch_monitor_config[CFG_MONITOR_BIT];
  assign sw_en = i_switch_monitor_config[CFG_SWITCH_BIT];

  // Backup is never watched: nothing is left to fall back to
  assign det_en = mon_en && (cur_reg.mode == MODE_NORMAL) && (cur_reg.src != SRC_BACKUP);

  fcm_activity_det #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_det (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_enable(det_en),
    .i_osc_level(i_osc_activity),
    .o_fail(det_fail)
  );

  // Event sources
  assign fail_event = mon_en && det_fail && !cur_reg.det_fail_d;
  assign sw_event = i_clock_fail_flag_wr && i_clock_fail_flag_wdata;
  assign nmi_set = i_nmi_fail_flag_wr && i_nmi_fail_flag_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    cur_next = cur_reg;
    cur_next.det_fail_d = det_fail;
    cur_next.rejected = 1'b0;
    // Clear first so an event in the same cycle wins
    if (i_clock_fail_flag_wr && !i_clock_fail_flag_wdata) begin
      cur_next.fail_flag = 1'b0;
    end
    if (fail_event || sw_event) begin
      cur_next.fail_flag = 1'b1;
    end
    if (i_nmi_fail_flag_wr && !i_nmi_fail_flag_wdata) begin
      cur_next.nmi_flag = 1'b0;
    end
    if (fail_event || sw_event || nmi_set) begin
      cur_next.nmi_flag = 1'b1;
    end
    // NMI stays requested while either flag stands
    cur_next.nmi_req = cur_next.fail_flag || cur_next.nmi_flag;
    // Software selection, refused when locked or switching disabled
    if (i_source_sel_wr) begin
      if (cur_reg.lock || !sw_en) begin
        cur_next.rejected = 1'b1;
      end else begin
        cur_next.src = i_source_sel_wdata;
      end
    end
    if (i_pll_sel_wr) begin
      if (cur_reg.lock || !sw_en) begin
        cur_next.rejected = 1'b1;
      end else begin
        cur_next.pll = i_pll_sel_wdata;
      end
    end
    // Failover overrides a software source choice in the same cycle
    if (fail_event || sw_event) begin
      cur_next.src = SRC_BACKUP;
    end
    // Lock moves only on its own write, never on a monitor event
    if (i_clock_select_lock_wr) begin
      cur_next.lock = i_clock_select_lock_wdata;
    end
    // Failure mode ends once software clears the fail flag
    case (cur_reg.mode)
      MODE_NORMAL: begin
        if (fail_event || sw_event) begin
          cur_next.mode = MODE_FAILED;
        end
      end
      MODE_FAILED: begin
        if (!cur_next.fail_flag) begin
          cur_next.mode = MODE_NORMAL;
        end
      end
      default: begin
        cur_next.mode = MODE_NORMAL;
      end
    endcase
    // Readback images of the two control registers
    cur_next.osc_view = '0;
    cur_next.osc_view[OSC_FAIL_BIT] = cur_next.fail_flag;
    cur_next.osc_view[OSC_LOCK_BIT] = cur_next.lock;
    cur_next.nmi_view = '0;
    cur_next.nmi_view[NMI_FAIL_BIT] = cur_next.nmi_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cur_reg <= '0;
      cur_reg.mode <= MODE_NORMAL;
      cur_reg.src <= RST_SOURCE;
      cur_reg.pll <= RST_PLL;
      cur_reg.lock <= RST_LOCK;
      cur_reg.osc_view[OSC_LOCK_BIT] <= RST_LOCK;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs straight from the state register
  assign o_active_source = cur_reg.src;
  assign o_pll_select = cur_reg.pll;
  assign o_select_rejected = cur_reg.rejected;
  assign o_clock_fail_flag = cur_reg.fail_flag;
  assign o_nmi_fail_flag = cur_reg.nmi_flag;
  assign o_nmi_request = cur_reg.nmi_req;
  assign o_clock_select_lock = cur_reg.lock;
  assign o_monitor_failed_mode = (cur_reg.mode == MODE_FAILED);
  assign o_osc_ctrl_view = cur_reg.osc_view;
  assign o_nmi_ctrl_view = cur_reg.nmi_view;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_fail_to_backup: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    fail_event |=> (o_active_source == SRC_BACKUP) && o_monitor_failed_mode)
    else $error("failure did not switch to backup oscillator");

  chk_fail_raises_nmi: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    fail_event |=> o_nmi_request && o_nmi_fail_flag)
    else $error("failure did not raise NMI");

  chk_monitor_off: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (!i_switch_monitor_config[CFG_MONITOR_BIT] && !sw_event) |=> !$rose(o_clock_fail_flag))
    else $error("failure flagged with monitoring disabled");

  chk_switch_off: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (i_source_sel_wr && !i_switch_monitor_config[CFG_SWITCH_BIT] && !fail_event && !sw_event)
    |=> $stable(o_active_source) && o_select_rejected)
    else $error("source changed with switching disabled");

  chk_sw_event: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    sw_event |=> o_clock_fail_flag && (o_active_source == SRC_BACKUP) && o_nmi_request)
    else $error("software fail write did not start monitor event");

  chk_nmi_only: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (nmi_set && !fail_event && !sw_event && !i_source_sel_wr && !i_clock_fail_flag_wr)
    |=> o_nmi_request && o_nmi_fail_flag && $stable(o_active_source) && $stable(o_clock_fail_flag))
    else $error("NMI flag write misbehaved");

  chk_lock_reject: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (o_clock_select_lock && i_pll_sel_wr) |=> $stable(o_pll_select) && o_select_rejected)
    else $error("PLL selection changed while locked");

  chk_lock_stable: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    !i_clock_select_lock_wr |=> $stable(o_clock_select_lock))
    else $error("lock bit changed without its own write");

  chk_flag_hold: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (o_clock_fail_flag && !i_clock_fail_flag_wr)
    |=> o_clock_fail_flag && o_nmi_request && o_monitor_failed_mode)
    else $error("fail flag or NMI request dropped before clear");

  chk_nmi_hold: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (o_nmi_fail_flag && !i_nmi_fail_flag_wr) |=> o_nmi_fail_flag && o_nmi_request)
    else $error("NMI flag dropped without clear");

  // Main scenarios
  cov_hw_failure: cover property (@(posedge i_clock) disable iff (!i_nrst) fail_event);
  cov_sw_event: cover property (@(posedge i_clock) disable iff (!i_nrst) sw_event);
  cov_locked_reject: cover property (
    @(posedge i_clock) disable iff (!i_nrst) o_clock_select_lock && i_source_sel_wr);
  cov_recover: cover property (
    @(posedge i_clock) disable iff (!i_nrst) o_monitor_failed_mode ##1 !o_monitor_failed_mode);

endmodule // fcm_core

// [verification/fcm_osc_model.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Monitored primary oscillator as seen through its level sampler
module fcm_osc_model (
  // Clock and run control
  input wire logic i_clock,
  input wire logic i_run,
  // Sampled oscillator level
  output logic o_level = 1'b0
);
  // Toggles while alive; a dead crystal freezes at its last level
  always @(posedge i_clock) begin
    if (i_run) begin
      o_level <= ~o_level;
    end
  end
endmodule // fcm_osc_model

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench
  import fcm_pkg::*;
();
  // Short timeout keeps failover scenarios brief
  localparam int TMO = 4;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [1:0] cfg = 2'h3;
  logic run = 1'b1;
  logic osc;
  logic flag_wr = 1'b0, flag_wd = 1'b0, nf_wr = 1'b0, nf_wd = 1'b0;
  logic lk_wr = 1'b0, lk_wd = 1'b0, src_wr = 1'b0, pll_wr = 1'b0;
  logic [SRC_W-1:0] src_wd = 3'h0;
  logic [PLL_W-1:0] pll_wd = 3'h0;
  logic [SRC_W-1:0] src;
  logic [PLL_W-1:0] pll;
  logic rej, flag, nf, nmi, lock, mode;
  logic [CTRL_W-1:0] oview, nview;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #4 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end
  fcm_osc_model u_osc (.i_clock(i_clock), .i_run(run), .o_level(osc));
  fcm_core #(.TIMEOUT_CYC(TMO)) u_dut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_switch_monitor_config(cfg),
    .i_osc_activity(osc), .i_clock_fail_flag_wr(flag_wr), .i_clock_fail_flag_wdata(flag_wd),
    .i_nmi_fail_flag_wr(nf_wr), .i_nmi_fail_flag_wdata(nf_wd),
    .i_clock_select_lock_wr(lk_wr), .i_clock_select_lock_wdata(lk_wd),
    .i_source_sel_wr(src_wr), .i_source_sel_wdata(src_wd), .i_pll_sel_wr(pll_wr),
    .i_pll_sel_wdata(pll_wd), .o_active_source(src), .o_pll_select(pll),
    .o_select_rejected(rej), .o_clock_fail_flag(flag), .o_nmi_fail_flag(nf),
    .o_nmi_request(nmi), .o_clock_select_lock(lock), .o_monitor_failed_mode(mode),
    .o_osc_ctrl_view(oview), .o_nmi_ctrl_view(nview));
  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    i_nrst = 1'b0;
    repeat (2) @(negedge i_clock);
    i_nrst = 1'b1;
  endtask
  // One write pulse; an extra edge first so strobes never flip twice at once
  task automatic wr(input int k, input logic [2:0] d);
    @(negedge i_clock);
    case (k)
      0: begin
        flag_wr = 1'b1;
        flag_wd = d[0];
      end
      1: begin
        nf_wr = 1'b1;
        nf_wd = d[0];
      end
      2: begin
        lk_wr = 1'b1;
        lk_wd = d[0];
      end
      3: begin
        src_wr = 1'b1;
        src_wd = d;
      end
      default: begin
        pll_wr = 1'b1;
        pll_wd = d;
      end
    endcase
    @(negedge i_clock);
    {flag_wr, nf_wr, lk_wr, src_wr, pll_wr} = 5'h00;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk({5'h00, src}, {5'h00, RST_SOURCE});
    chk({rej, flag, nf, nmi, lock, mode, pll[1:0]}, 8'h00);
    chk(oview | nview, 8'h00);
    $display("Test reset done");
  endtask
  task automatic t_monitor();
    int n;
    do_reset();
    cfg = 2'h3;
    wr(2, 3'h1);
    run = 1'b0;
    n = 0;
    while (flag !== 1'b1 && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    chk(8'(n >= TMO + 1 && n <= TMO + 6), 8'h01);
    chk({5'h00, src}, {5'h00, SRC_BACKUP});
    chk({4'h0, nf, nmi, lock, mode}, 8'h0F);
    chk(oview, 8'h88);
    chk(nview, 8'h02);
    run = 1'b1;
    repeat (10) @(negedge i_clock);
    chk({5'h00, flag, nmi, mode}, 8'h07);
    wr(0, 3'h0);
    chk({4'h0, flag, nmi, lock, mode}, 8'h06);
    wr(1, 3'h0);
    chk({6'h00, nmi, lock}, 8'h01);
    $display("Test monitor done");
  endtask
  // Every config code: switching gates selection, monitoring gates failover
  task automatic t_cfg();
    for (int c = 0; c < 4; c++) begin
      do_reset();
      cfg = 2'(c);
      wr(3, SRC_FAST_INTERNAL);
      chk({7'h00, rej}, {7'h00, ~cfg[0]});
      chk({5'h00, src}, cfg[0] ? 8'h00 : 8'h02);
      if (cfg[0]) wr(3, SRC_PRIMARY);
      run = 1'b0;
      repeat (TMO + 12) @(negedge i_clock);
      chk({7'h00, flag}, {7'h00, cfg[1]});
      chk({5'h00, src}, cfg[1] ? 8'h07 : 8'h02);
      run = 1'b1;
    end
    $display("Test config done");
  endtask
  task automatic t_lock();
    do_reset();
    cfg = 2'h3;
    wr(2, 3'h1);
    wr(4, 3'h5);
    chk({4'h0, rej, pll}, 8'h08);
    wr(3, SRC_FAST_INTERNAL);
    chk({4'h0, rej, src}, 8'h0A);
    wr(2, 3'h0);
    wr(4, 3'h5);
    chk({4'h0, rej, pll}, 8'h05);
    $display("Test lock done");
  endtask
  task automatic t_soft();
    do_reset();
    cfg = 2'h3;
    wr(1, 3'h1);
    chk({4'h0, nf, nmi, flag, mode}, 8'h0C);
    chk({5'h00, src}, 8'h02);
    wr(1, 3'h0);
    wr(0, 3'h1);
    chk({4'h0, flag, nmi, mode, lock}, 8'h0E);
    chk({5'h00, src}, {5'h00, SRC_BACKUP});
    $display("Test software write done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic close_out();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge i_clock);
    i_nrst = 1'b1;
    @(negedge i_clock);
    t_reset();
    t_monitor();
    t_cfg();
    t_lock();
    t_soft();
    close_out();
  end
endmodule // testbench
